// ===== design/rcw_config_top.v
// Calibration and wake-up configuration register with its AXI4-Lite slave.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`default_nettype none
`timescale 1ns/1ps
`include "rcw_map.vh"

// Notes on behaviour
// - Select 00 never calibrates automatically; only the manual strobe calibrates.
// - Select 01 calibrates on every idle to transmit or synth-on move.
// - Select 10 calibrates on every transmit to idle move.
// - Select 11 calibrates on every fourth transmit to idle move.
// - Calibration select resets to zero, automatic calibration off.
// - Chip ready stays high until enough ripple expirations after oscillator stable.
// - Wait select resets to one; duration scales with crystal frequency.
// - Oscillator is off in power-down; the wait restarts afterwards.
// - Wait select survives sleep; other configuration is lost.
// - After-send field picks idle, synth-on or stay in transmit; 11 unused.
module rcw_config_top #(
    parameter RIPPLE_WIDTH = 6
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        ce,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        calibrate_synth_strobe,
    input  wire        idle_to_tx_pulse,
    input  wire        tx_to_idle_pulse,
    input  wire        tx_done_pulse,
    input  wire        power_down,
    input  wire        osc_stable,
    output reg         synth_calibrate_start,
    output reg  [1:0]  after_send_next_state,
    output reg         osc_enable,
    output wire        chip_ready_low
);

    reg [1:0]  auto_calib_select_reg;
    reg [1:0]  osc_wait_count_sel_reg;
    reg [1:0]  after_send_state_sel_reg;
    reg [1:0]  fourth_cnt_reg;
    reg        power_down_d_reg;
    reg [7:0]  aw_addr_reg;
    reg        aw_full_reg;
    reg [31:0] w_data_reg;
    reg        w_strb0_reg;
    reg        w_full_reg;
    wire       sleep_enter;
    wire       do_write;
    wire       fourth_hit;
    reg        cal_next;
    reg [31:0] rdata_next;
    reg [1:0]  rresp_next;

    assign sleep_enter = power_down & ~power_down_d_reg;
    assign do_write    = aw_full_reg & w_full_reg & ~s_axi_bvalid;
    assign fourth_hit  = (fourth_cnt_reg == `RCW_FOURTH_LAST);

    // Address and data are latched independently so the master may offer them in any order.
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_reg   <= 8'h00;
            aw_full_reg   <= 1'b0;
            w_data_reg    <= 32'h00000000;
            w_strb0_reg   <= 1'b0;
            w_full_reg    <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RCW_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_reg   <= s_axi_awaddr;
                aw_full_reg   <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_reg   <= s_axi_wdata;
                w_strb0_reg  <= s_axi_wstrb[0];
                w_full_reg   <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_full_reg  <= 1'b0;
                w_full_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr_reg[7:2] == `RCW_ADDR_SM_CFG_B >> 2 ||
                    aw_addr_reg[7:2] == `RCW_ADDR_AFTER_SEND >> 2 ||
                    aw_addr_reg[7:2] == `RCW_ADDR_STATUS >> 2) begin
                    s_axi_bresp <= `RCW_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `RCW_RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Configuration fields. Entering sleep drops the calibration and after-send
    // settings but keeps the wait selection, so the next start-up waits the same full count.
    always @(posedge aclk) begin
        if (!aresetn) begin
            auto_calib_select_reg    <= `RCW_AUTOCAL_RESET;
            osc_wait_count_sel_reg   <= `RCW_OSCWAIT_RESET;
            after_send_state_sel_reg <= `RCW_AFTER_SEND_RESET;
            power_down_d_reg         <= 1'b0;
        end else if (ce) begin
            power_down_d_reg <= power_down;
            if (sleep_enter) begin
                auto_calib_select_reg    <= `RCW_AUTOCAL_RESET;
                after_send_state_sel_reg <= `RCW_AFTER_SEND_RESET;
            end else if (do_write && w_strb0_reg) begin
                // Only the documented field bits are stored; the rest is dropped.
                if (aw_addr_reg[7:2] == `RCW_ADDR_SM_CFG_B >> 2) begin
                    auto_calib_select_reg  <= w_data_reg[`RCW_AUTOCAL_MSB:`RCW_AUTOCAL_LSB];
                    osc_wait_count_sel_reg <= w_data_reg[`RCW_OSCWAIT_MSB:`RCW_OSCWAIT_LSB];
                end
                if (aw_addr_reg[7:2] == `RCW_ADDR_AFTER_SEND >> 2) begin
                    after_send_state_sel_reg <=
                        w_data_reg[`RCW_AFTER_SEND_MSB:`RCW_AFTER_SEND_LSB];
                end
            end
        end
    end

    // Read data mux; unused bits and unmapped words return zero.
    always @* begin
        rdata_next = 32'h00000000;
        rresp_next = `RCW_RESP_OKAY;
        if (s_axi_araddr[7:2] == `RCW_ADDR_SM_CFG_B >> 2) begin
            rdata_next[`RCW_AUTOCAL_MSB:`RCW_AUTOCAL_LSB] = auto_calib_select_reg;
            rdata_next[`RCW_OSCWAIT_MSB:`RCW_OSCWAIT_LSB] = osc_wait_count_sel_reg;
        end else if (s_axi_araddr[7:2] == `RCW_ADDR_AFTER_SEND >> 2) begin
            rdata_next[`RCW_AFTER_SEND_MSB:`RCW_AFTER_SEND_LSB] = after_send_state_sel_reg;
        end else if (s_axi_araddr[7:2] == `RCW_ADDR_STATUS >> 2) begin
            rdata_next[0]   = ~chip_ready_low;
            rdata_next[1]   = osc_enable;
            rdata_next[3:2] = fourth_cnt_reg;
        end else begin
            rresp_next = `RCW_RESP_SLVERR;
        end
    end

    // Read channel: one read at a time, answered one cycle after the address is taken.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RCW_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rdata_next;
                s_axi_rresp   <= rresp_next;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Calibration trigger decision for this cycle.
    always @* begin
        cal_next = calibrate_synth_strobe;
        case (auto_calib_select_reg)
            `RCW_CAL_NEVER:        cal_next = calibrate_synth_strobe;
            `RCW_CAL_IDLE_TO_TX:   cal_next = calibrate_synth_strobe | idle_to_tx_pulse;
            `RCW_CAL_TX_TO_IDLE:   cal_next = calibrate_synth_strobe | tx_to_idle_pulse;
            `RCW_CAL_EVERY_FOURTH: cal_next = calibrate_synth_strobe |
                                              (tx_to_idle_pulse & fourth_hit);
            default:               cal_next = calibrate_synth_strobe;
        endcase
    end

    // Calibration pulse, fourth-return counter, next state after send and oscillator enable.
    // The counter only runs in the every-fourth mode, so switching in starts a fresh count.
    always @(posedge aclk) begin
        if (!aresetn) begin
            synth_calibrate_start <= 1'b0;
            fourth_cnt_reg        <= 2'h0;
            after_send_next_state <= `RCW_NEXT_IDLE;
            osc_enable            <= 1'b0;
        end else if (ce) begin
            synth_calibrate_start <= cal_next;
            osc_enable            <= ~power_down;
            if (auto_calib_select_reg != `RCW_CAL_EVERY_FOURTH) begin
                fourth_cnt_reg <= 2'h0;
            end else if (tx_to_idle_pulse) begin
                fourth_cnt_reg <= fourth_cnt_reg + 2'h1;
            end
            if (tx_done_pulse) begin
                case (after_send_state_sel_reg)
                    `RCW_NEXT_SYNTH_ON: after_send_next_state <= `RCW_NEXT_SYNTH_ON;
                    `RCW_NEXT_STAY_TX:  after_send_next_state <= `RCW_NEXT_STAY_TX;
                    default:            after_send_next_state <= `RCW_NEXT_IDLE;
                endcase
            end
        end
    end

    // Start-up wait runs only while the oscillator is on and reports stable.
    rcw_wake_timer #(
        .RIPPLE_WIDTH (RIPPLE_WIDTH)
    ) u_wake_timer (
        .aclk               (aclk),
        .aresetn            (aresetn),
        .ce                 (ce),
        .osc_running        (osc_enable & osc_stable),
        .osc_wait_count_sel (osc_wait_count_sel_reg),
        .chip_ready_low     (chip_ready_low)
    );

endmodule // rcw_config_top
`default_nettype wire

// ===== design/rcw_map.vh
// Address map, field positions and reset values of the radio calibration and wake-up block.
`ifndef RCW_MAP_VH
`define RCW_MAP_VH

`define RCW_ADDR_SM_CFG_B      8'h18
`define RCW_ADDR_AFTER_SEND    8'h1C
`define RCW_ADDR_STATUS        8'h20

`define RCW_AUTOCAL_LSB        4
`define RCW_AUTOCAL_MSB        5
`define RCW_OSCWAIT_LSB        2
`define RCW_OSCWAIT_MSB        3
`define RCW_AFTER_SEND_LSB     0
`define RCW_AFTER_SEND_MSB     1

`define RCW_AUTOCAL_RESET      2'h0
`define RCW_OSCWAIT_RESET      2'h1
`define RCW_AFTER_SEND_RESET   2'h0

`define RCW_CAL_NEVER          2'h0
`define RCW_CAL_IDLE_TO_TX     2'h1
`define RCW_CAL_TX_TO_IDLE     2'h2
`define RCW_CAL_EVERY_FOURTH   2'h3
`define RCW_FOURTH_LAST        2'h3

`define RCW_NEXT_IDLE          2'h0
`define RCW_NEXT_SYNTH_ON      2'h1
`define RCW_NEXT_STAY_TX       2'h2

`define RCW_RESP_OKAY          2'h0
`define RCW_RESP_SLVERR        2'h2

`define RCW_EXPIRE_SEL0        9'h001
`define RCW_EXPIRE_SEL1        9'h010
`define RCW_EXPIRE_SEL2        9'h040
`define RCW_EXPIRE_SEL3        9'h100

`endif

// ===== design/rcw_wake_timer.v
// Crystal start-up wait: counts ripple counter expirations before signalling chip ready.
`default_nettype none
`timescale 1ns/1ps
`include "rcw_map.vh"

module rcw_wake_timer #(
    parameter RIPPLE_WIDTH = 6
) (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       ce,
    input  wire       osc_running,
    input  wire [1:0] osc_wait_count_sel,
    output reg        chip_ready_low
);

    reg [RIPPLE_WIDTH-1:0] ripple_reg;
    reg [8:0]              expire_cnt_reg;

    // Required expiration count for each wait selection.
    function [8:0] expire_target;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    expire_target = `RCW_EXPIRE_SEL0;
                2'h1:    expire_target = `RCW_EXPIRE_SEL1;
                2'h2:    expire_target = `RCW_EXPIRE_SEL2;
                default: expire_target = `RCW_EXPIRE_SEL3;
            endcase
        end
    endfunction

    // The wait restarts whenever the oscillator stops, so every power-up waits in full.
    // The target is compared live; a later change of the selection only moves the goal.
    always @(posedge aclk) begin
        if (!aresetn) begin
            ripple_reg     <= {RIPPLE_WIDTH{1'b0}};
            expire_cnt_reg <= 9'h000;
            chip_ready_low <= 1'b1;
        end else if (ce) begin
            if (!osc_running) begin
                ripple_reg     <= {RIPPLE_WIDTH{1'b0}};
                expire_cnt_reg <= 9'h000;
                chip_ready_low <= 1'b1;
            end else if (chip_ready_low) begin
                ripple_reg <= ripple_reg + 1'b1;
                if (&ripple_reg) begin
                    expire_cnt_reg <= expire_cnt_reg + 9'h001;
                    if (expire_cnt_reg + 9'h001 >= expire_target(osc_wait_count_sel)) begin
                        chip_ready_low <= 1'b0;
                    end
                end
            end
        end
    end

endmodule // rcw_wake_timer
`default_nettype wire

// ===== test/rcw_config_monitor.sv
// Concurrent checks on the calibration and wake-up block's outputs.
`timescale 1ns/1ps
`default_nettype none
module rcw_config_monitor #(
    parameter RIPPLE_WIDTH = 6
) (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       ce,
    input wire logic       calibrate_synth_strobe,
    input wire logic       idle_to_tx_pulse,
    input wire logic       tx_to_idle_pulse,
    input wire logic       tx_done_pulse,
    input wire logic       power_down,
    input wire logic       osc_stable,
    input wire logic       synth_calibrate_start,
    input wire logic [1:0] after_send_next_state,
    input wire logic       osc_enable,
    input wire logic       chip_ready_low
);
    localparam int MIN_RUN = (1 << RIPPLE_WIDTH) - 1;
    logic [11:0] run_cnt;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Unbroken run of the oscillator; ready can never come before one full ripple pass.
    always_ff @(posedge aclk) begin
        if (!aresetn || !(osc_enable && osc_stable))
            run_cnt <= 12'h000;
        else if (ce && !run_cnt[11])
            run_cnt <= run_cnt + 12'h001;
    end

    property p_cal_strobe; ce && calibrate_synth_strobe |=> synth_calibrate_start; endproperty
    a_cal_strobe: assert property (p_cal_strobe) else $error("strobe gave no start");
    property p_cal_quiet;
        ce && !(calibrate_synth_strobe || idle_to_tx_pulse || tx_to_idle_pulse)
            |=> !synth_calibrate_start;
    endproperty
    a_cal_quiet: assert property (p_cal_quiet) else $error("start without trigger");
    property p_osc_follow; ce |=> osc_enable != $past(power_down); endproperty
    a_osc_follow: assert property (p_osc_follow) else $error("oscillator ignores sleep");
    property p_ready_off; ce && !(osc_enable && osc_stable) |=> chip_ready_low; endproperty
    a_ready_off: assert property (p_ready_off) else $error("ready while idle");
    property p_ready_start; ce && $rose(osc_enable) |-> chip_ready_low [*3]; endproperty
    a_ready_start: assert property (p_ready_start) else $error("ready too soon");
    property p_ready_early; $fell(chip_ready_low) |-> run_cnt >= MIN_RUN; endproperty
    a_ready_early: assert property (p_ready_early) else $error("ready before one pass");
    property p_after_hold; ce && !tx_done_pulse |=> $stable(after_send_next_state); endproperty
    a_after_hold: assert property (p_after_hold) else $error("next state moved");
    property p_after_legal; after_send_next_state != 2'h3; endproperty
    a_after_legal: assert property (p_after_legal) else $error("unused next state");
    property p_freeze;
        !ce |=> $stable(synth_calibrate_start) && $stable(osc_enable) && $stable(chip_ready_low);
    endproperty
    a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");

    c_cal: cover property (synth_calibrate_start);
    c_ready: cover property ($fell(chip_ready_low));
    c_sleep: cover property ($fell(osc_enable));
endmodule // rcw_config_monitor
`default_nettype wire

// ===== test/rcw_xtal_model.sv
// Crystal oscillator stand-in: stable some cycles after enable, dead at once when disabled.
`timescale 1ns/1ps
`default_nettype none
module rcw_xtal_model #(
    parameter int START_CYCLES = 3
) (
    input  wire logic aclk,
    input  wire logic osc_enable,
    output wire logic osc_stable
);
    int run = 0;
    // Start-up begins again from zero each time the oscillator is switched off.
    always @(posedge aclk) begin
        if (!osc_enable)
            run <= 0;
        else if (run < START_CYCLES)
            run <= run + 1;
    end
    assign osc_stable = osc_enable && (run == START_CYCLES);
endmodule // rcw_xtal_model
`default_nettype wire

// ===== test/radio_calib_and_wakeup_config_test.sv
// Self-checking bench for the calibration and wake-up configuration block.
`timescale 1ns/1ps
`default_nettype none
`include "rcw_map.vh"
module radio_calib_and_wakeup_config_test;
    localparam int RW = 2;
    logic        aclk, aresetn, ce, power_down, osc_stable, osc_enable, chip_ready_low;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        synth_calibrate_start;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, trig;
    logic [1:0]  s_axi_bresp, s_axi_rresp, after_send_next_state;
    wire logic   calibrate_synth_strobe, idle_to_tx_pulse, tx_to_idle_pulse, tx_done_pulse;
    int          fails = 0, checks = 0, cycles = 0, cals = 0, n;
    int          exp_cal[4] = '{1, 2, 5, 2};
    int          exp_n[4] = '{1, 16, 64, 256};

    assign {tx_done_pulse, tx_to_idle_pulse, idle_to_tx_pulse, calibrate_synth_strobe} = trig;
    rcw_config_top #(.RIPPLE_WIDTH(RW)) DUT (.*);
    rcw_xtal_model XTAL (.*);

    // Free-running 100 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // Calibration starts are tallied; running past the ceiling counts as a failure.
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (synth_calibrate_start === 1'b1)
            cals <= cals + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks = checks + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("unexpected at %0t: got %h, expected %h", $time, g, e);
        end
    endtask

    // Address and data go out together; released lines show the inverse, never a stale value.
    task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                       input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (!s_axi_awvalid && !s_axi_wvalid && s_axi_bvalid && s_axi_bready) begin
                s_axi_bready <= 1'b0;
                chk(s_axi_bresp, er);
            end
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
        end while (s_axi_bready);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (!s_axi_arvalid && s_axi_rvalid && s_axi_rready) begin
                s_axi_rready <= 1'b0;
                chk(s_axi_rdata, e);
                chk(s_axi_rresp, er);
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
        end while (s_axi_rready);
    endtask

    // One-cycle trigger pulse, then two quiet cycles so the start has been tallied.
    task automatic fire(input int i);
        trig <= 4'h1 << i;
        @(posedge aclk);
        trig <= 4'h0;
        repeat (2) @(posedge aclk);
    endtask

    task automatic conclude();
        if (fails == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Reset, then register access, calibration modes, after-send choice and wake-up waits.
    initial begin
        {ce, aresetn, power_down, trig} = 7'h40;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(8'h18, 32'h4, `RCW_RESP_OKAY);
        wrc(8'h18, 32'hFFFFFFFF, 4'hF, `RCW_RESP_OKAY);
        rdc(8'h18, 32'h3C, `RCW_RESP_OKAY);
        wrc(8'h18, 32'h0, 4'hE, `RCW_RESP_OKAY);
        rdc(8'h18, 32'h3C, `RCW_RESP_OKAY);
        wrc(8'h40, 32'h0, 4'hF, `RCW_RESP_SLVERR);
        rdc(8'h40, 32'h0, `RCW_RESP_SLVERR);
        for (int sel = 0; sel < 4; sel++) begin
            wrc(8'h18, sel * 16 + 8, 4'hF, `RCW_RESP_OKAY);
            n = cals;
            fire(1);
            repeat (4) fire(2);
            fire(0);
            chk(cals - n, exp_cal[sel]);
        end
        for (int v = 0; v < 4; v++) begin
            wrc(8'h1C, v, 4'hF, `RCW_RESP_OKAY);
            fire(3);
            chk(after_send_next_state, v % 3);
        end
        // A strobe offered while the clock enable is low must leave no trace.
        ce <= 1'b0;
        n = cals;
        fire(0);
        ce <= 1'b1;
        chk(cals - n, 0);
        for (int sel = 0; sel < 4; sel++) begin
            wrc(8'h18, sel * 4 + 48, 4'hF, `RCW_RESP_OKAY);
            wrc(8'h1C, 32'h2, 4'hF, `RCW_RESP_OKAY);
            power_down <= 1'b1;
            repeat (3) @(posedge aclk);
            chk({chip_ready_low, osc_enable}, 2'h2);
            rdc(8'h18, sel * 4, `RCW_RESP_OKAY);
            rdc(8'h1C, 32'h0, `RCW_RESP_OKAY);
            power_down <= 1'b0;
            n = 0;
            while (chip_ready_low !== 1'b0 && n < 2000) begin
                @(posedge aclk);
                n++;
            end
            chk(n >= 4 * exp_n[sel] && n <= 4 * exp_n[sel] + 8, 1);
            rdc(8'h20, 32'h3, `RCW_RESP_OKAY);
        end
        conclude();
    end
endmodule // radio_calib_and_wakeup_config_test

bind rcw_config_top rcw_config_monitor #(.RIPPLE_WIDTH(RIPPLE_WIDTH)) MON (.*);
`default_nettype wire
